// >>> logic/esr_pkg.sv
// Purpose: Shared constants for the serial position encoder response block.
// Assumes: 40 MHz system clock, AHB-Lite register access, 32-bit data.
// Notes: Line bit time and init time are nominal figures, converted to cycles here.
package esr_pkg;
   // Clock and timing
   localparam int CLK_HZ = 40_000_000;
   localparam int GAP_US = 40;
   localparam int GAP_CYC = (GAP_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int BIT_NS = 400;
   localparam int BIT_CYC = BIT_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int INIT_US = 1000;
   localparam int INIT_CYC = INIT_US * (CLK_HZ / 1_000_000);
   localparam logic [3:0] RESET_REPEAT = 4'hA;

   // Request codes as seen on the line
   localparam logic [7:0] CODE_SHORT = 8'hA2;
   localparam logic [7:0] CODE_LONG = 8'h2A;
   localparam logic [7:0] CODE_ERR_RST = 8'hDA;
   localparam logic [7:0] CODE_POS_ZERO = 8'h7A;

   // Alarm byte layout
   localparam int ALM_OVERSPEED = 0;
   localparam int ALM_INIT = 1;
   localparam int ALM_NVHW = 2;
   localparam int ALM_LOWAMP = 5;
   localparam logic [7:0] ALM_CLR_ON_RESET = 8'h25;

   // Status byte layout
   localparam int SF_WARN = 6;
   localparam int SF_ERR = 7;

   // Resolution select and masks of the 24-bit field
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [23:0] MASK_24 = 24'hFF_FFFF;
   localparam logic [23:0] MASK_23 = 24'h7F_FFFF;
   localparam logic [23:0] MASK_22 = 24'h3F_FFFF;
   localparam logic [23:0] MASK_20 = 24'h0F_FFFF;

   // Register offsets
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATE = 12'h004;
   localparam logic [11:0] REG_IRQ_STAT = 12'h008;
   localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
   localparam logic [11:0] REG_POS_LO = 12'h010;
   localparam logic [11:0] REG_POS_HI = 12'h014;

   // Interrupt bits
   localparam int NUM_IRQ = 5;
   localparam int IRQ_RESP = 0;
   localparam int IRQ_ERR_RST = 1;
   localparam int IRQ_POS_ZERO = 2;
   localparam int IRQ_ALARM = 3;
   localparam int IRQ_RX_FAULT = 4;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_SEND, ST_NV} esr_state_e;
endpackage : esr_pkg

// >>> logic/esr_line_rx.sv
// Purpose: Receives one framed byte: low start bit, 8 data bits LSB first, high delimiter.
// Assumes: line_in synchronous to hclk.
// Notes: A start bit that is high again at mid-bit is dropped as a glitch.
`timescale 1ns/1ps
module esr_line_rx #(
   parameter int BIT_CYC = 16
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic enable, // Receive allowed
   input wire logic line_in, // Serial line level
   output logic byte_valid, // Pulse, byte received
   output logic [7:0] byte_data, // Received byte
   output logic frame_err // Pulse, bad delimiter
);
   localparam int CW = $clog2(BIT_CYC);
   logic busy_reg;
   logic [CW-1:0] cnt_reg;
   logic [3:0] idx_reg;
   logic [7:0] shift_reg;

   // Mid-bit sampling of each field bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         cnt_reg <= '0;
         idx_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
         frame_err <= 1'b0;
      end else begin
         byte_valid <= 1'b0;
         frame_err <= 1'b0;
         if (!busy_reg) begin
            if (enable && !line_in) begin
               busy_reg <= 1'b1;
               cnt_reg <= CW'(BIT_CYC / 2 - 1);
               idx_reg <= 4'h0;
            end
         end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
         end else begin
            cnt_reg <= CW'(BIT_CYC - 1);
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == 4'h0) begin
               if (line_in) begin
                  busy_reg <= 1'b0; // False start
               end
            end else if (idx_reg <= 4'h8) begin
               shift_reg <= {line_in, shift_reg[7:1]}; // LSB arrives first
            end else begin
               busy_reg <= 1'b0;
               if (line_in) begin
                  byte_valid <= 1'b1;
                  byte_data <= shift_reg;
               end else begin
                  frame_err <= 1'b1;
               end
            end
         end
      end
   end
endmodule : esr_line_rx

// >>> logic/esr_line_tx.sv
// Purpose: Sends framed bytes and drives the half-duplex driver enable.
// Assumes: One byte accepted per valid/ready handshake.
// Notes: Driver stays on while hold is high so bytes of one answer run together.
`timescale 1ns/1ps
module esr_line_tx #(
   parameter int BIT_CYC = 16
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic byte_valid, // Byte offered
   input wire logic [7:0] byte_data, // Byte to send
   input wire logic hold, // Keep driver on between bytes
   output logic byte_ready, // Ready for a byte
   output logic line_out, // Serial line level
   output logic line_oe_n // Driver enable, low drives
);
   localparam int CW = $clog2(BIT_CYC);
   logic busy_reg;
   logic [CW-1:0] cnt_reg;
   logic [3:0] left_reg;
   logic [8:0] shift_reg;

   assign byte_ready = !busy_reg;

   // Start bit, 8 data bits LSB first, then delimiter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         cnt_reg <= '0;
         left_reg <= 4'h0;
         shift_reg <= 9'h1FF;
         line_out <= 1'b1;
      end else if (!busy_reg) begin
         line_out <= 1'b1;
         if (byte_valid) begin
            busy_reg <= 1'b1;
            shift_reg <= {1'b1, byte_data};
            line_out <= 1'b0;
            cnt_reg <= CW'(BIT_CYC - 1);
            left_reg <= 4'h9;
         end
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end else if (left_reg != 4'h0) begin
         line_out <= shift_reg[0];
         shift_reg <= {1'b1, shift_reg[8:1]};
         left_reg <= left_reg - 4'h1;
         cnt_reg <= CW'(BIT_CYC - 1);
      end else begin
         busy_reg <= 1'b0;
      end
   end

   // Driver enable follows the frame, not individual bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_oe_n <= 1'b1;
      end else begin
         line_oe_n <= !(hold || busy_reg || byte_valid);
      end
   end
endmodule : esr_line_tx

// >>> logic/esr_encoder_link.sv
// Purpose: Encoder end of the request/response position link with reset commands.
// Assumes: Sensor inputs synchronous to hclk; NV store handshakes req/done.
// Notes: Check byte of X^8+1 fed LSB first reduces to the XOR of the sent bytes.
`timescale 1ns/1ps
module esr_encoder_link #(
   parameter int INIT_CYCLES = esr_pkg::INIT_CYC,
   parameter int BIT_CYC = esr_pkg::BIT_CYC
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // AHB select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response, always OKAY
   output logic [31:0] hrdata, // AHB read data
   output logic irq, // Level interrupt
   input wire logic line_in, // RS-485 receive level
   output logic line_out, // RS-485 transmit level
   output logic line_oe_n, // RS-485 driver enable, low drives
   input wire logic [47:0] position_in, // Raw absolute position
   input wire logic overspeed_in, // Overspeed cause
   input wire logic low_amp_in, // Low amplitude cause
   input wire logic nv_fault_in, // NV memory fault
   input wire logic pos_invalid_in, // Position not detectable
   input wire logic [1:0] warn_in, // Warning causes, alarm bits 7:6
   input wire logic [47:0] nv_offset_in, // Stored zero point from NV
   output logic nv_write_req, // NV write request, level
   output logic [47:0] nv_write_data, // Zero point to store
   input wire logic nv_write_done // Pulse, NV write finished
);
   localparam int INIT_W = $clog2(INIT_CYCLES + 1);
   localparam int GAP_W = $clog2(esr_pkg::GAP_CYC + 1);

   esr_pkg::esr_state_e state_reg;
   logic [INIT_W-1:0] init_cnt_reg;
   logic [1:0] ctrl_reg;
   logic [47:0] offset_reg, pos48;
   logic [3:0] rep_cnt_reg, len_reg, idx_reg, rep_next;
   logic [GAP_W-1:0] gap_cnt_reg;
   logic [7:0] resp_reg [0:7];
   logic [esr_pkg::NUM_IRQ-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
   logic [esr_pkg::ADDR_W-1:0] wr_addr_reg;
   logic rx_valid, rx_err, tx_ready, tx_valid, init_fault_reg, wr_pend_reg;
   logic [7:0] rx_data, tx_data, alarm_code_byte, sf, lat_set, lat_reg, last_code_reg, crc_reg;
   logic [23:0] pos24, res_mask;
   logic ap_valid, rep_match, gap_ok, init_done, accept_rst;

   esr_line_rx #(.BIT_CYC(BIT_CYC)) u_rx (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(state_reg == esr_pkg::ST_IDLE),
      .line_in(line_in),
      .byte_valid(rx_valid),
      .byte_data(rx_data),
      .frame_err(rx_err)
   );

   esr_line_tx #(.BIT_CYC(BIT_CYC)) u_tx (
      .hclk(hclk),
      .hresetn(hresetn),
      .byte_valid(tx_valid),
      .byte_data(tx_data),
      .hold(state_reg == esr_pkg::ST_SEND),
      .byte_ready(tx_ready),
      .line_out(line_out),
      .line_oe_n(line_oe_n)
   );

   // Reported position, relative to the stored zero point
   assign pos48 = position_in - offset_reg;
   always_comb begin
      case (ctrl_reg)
         2'h1: res_mask = esr_pkg::MASK_23;
         2'h2: res_mask = esr_pkg::MASK_22;
         2'h3: res_mask = esr_pkg::MASK_20;
         default: res_mask = esr_pkg::MASK_24;
      endcase
   end
   assign pos24 = pos48[23:0] & res_mask;

   // Alarm byte and status byte; bits 3 and 4 are never raised
   assign alarm_code_byte = {warn_in, lat_reg[5:0]};
   always_comb begin
      sf = 8'h00;
      sf[esr_pkg::SF_ERR] = |lat_reg[5:0];
      sf[esr_pkg::SF_WARN] = |warn_in;
   end

   // Reset code repetition tracking
   assign gap_ok = gap_cnt_reg >= GAP_W'(esr_pkg::GAP_CYC - 1);
   assign rep_match = (rx_data == last_code_reg) && gap_ok && (rep_cnt_reg != 4'h0);
   assign rep_next = rep_match ? rep_cnt_reg + 4'h1 : 4'h1;
   assign accept_rst = rx_valid && (state_reg == esr_pkg::ST_IDLE)
      && ((rx_data == esr_pkg::CODE_ERR_RST) || (rx_data == esr_pkg::CODE_POS_ZERO))
      && (rep_next == esr_pkg::RESET_REPEAT);
   assign init_done = (state_reg == esr_pkg::ST_INIT) && (init_cnt_reg == '0);

   // Answer byte stream: echo and fields, then check byte last
   assign tx_valid = (state_reg == esr_pkg::ST_SEND);
   assign tx_data = (idx_reg == len_reg) ? crc_reg : resp_reg[idx_reg[2:0]];

   // Main sequence
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= esr_pkg::ST_INIT;
         init_cnt_reg <= INIT_W'(INIT_CYCLES);
         idx_reg <= 4'h0;
         len_reg <= 4'h0;
         crc_reg <= 8'h00;
         nv_write_req <= 1'b0;
      end else begin
         case (state_reg)
            esr_pkg::ST_INIT: begin
               if (init_cnt_reg != '0) begin
                  init_cnt_reg <= init_cnt_reg - 1'b1;
               end else begin
                  state_reg <= esr_pkg::ST_IDLE;
               end
            end
            esr_pkg::ST_IDLE: begin
               idx_reg <= 4'h0;
               crc_reg <= 8'h00;
               if (accept_rst && rx_data == esr_pkg::CODE_ERR_RST) begin
                  state_reg <= esr_pkg::ST_INIT;
                  init_cnt_reg <= INIT_W'(INIT_CYCLES);
               end else if (accept_rst) begin
                  state_reg <= esr_pkg::ST_NV;
                  nv_write_req <= 1'b1;
               end else if (rx_valid) begin
                  case (rx_data)
                     esr_pkg::CODE_SHORT, esr_pkg::CODE_ERR_RST, esr_pkg::CODE_POS_ZERO: begin
                        len_reg <= 4'h6;
                        state_reg <= esr_pkg::ST_SEND;
                     end
                     esr_pkg::CODE_LONG: begin
                        len_reg <= 4'h8;
                        state_reg <= esr_pkg::ST_SEND;
                     end
                     default: state_reg <= esr_pkg::ST_IDLE;
                  endcase
               end
            end
            esr_pkg::ST_SEND: begin
               if (tx_ready) begin
                  if (idx_reg == len_reg) begin
                     state_reg <= esr_pkg::ST_IDLE;
                  end else begin
                     crc_reg <= crc_reg ^ resp_reg[idx_reg[2:0]];
                     idx_reg <= idx_reg + 4'h1;
                  end
               end
            end
            esr_pkg::ST_NV: begin
               if (nv_write_done) begin
                  nv_write_req <= 1'b0;
                  state_reg <= esr_pkg::ST_IDLE;
               end
            end
            default: state_reg <= esr_pkg::ST_INIT;
         endcase
      end
   end

   // Answer contents, captured when the request arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 8; i++) begin
            resp_reg[i] <= 8'h00;
         end
      end else if (rx_valid && state_reg == esr_pkg::ST_IDLE) begin
         resp_reg[0] <= rx_data;
         resp_reg[1] <= sf;
         if (rx_data == esr_pkg::CODE_LONG) begin
            for (int i = 0; i < 6; i++) begin
               resp_reg[i + 2] <= pos48[8 * i +: 8];
            end
         end else begin
            resp_reg[2] <= pos24[7:0];
            resp_reg[3] <= pos24[15:8];
            resp_reg[4] <= pos24[23:16];
            resp_reg[5] <= alarm_code_byte;
            resp_reg[6] <= 8'h00;
            resp_reg[7] <= 8'h00;
         end
      end
   end

   // Repetition count and spacing since the previous received byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rep_cnt_reg <= 4'h0;
         last_code_reg <= 8'h00;
         gap_cnt_reg <= '0;
      end else if (rx_valid) begin
         gap_cnt_reg <= '0;
         last_code_reg <= rx_data;
         if (accept_rst) begin
            rep_cnt_reg <= 4'h0;
         end else if (rx_data == esr_pkg::CODE_ERR_RST || rx_data == esr_pkg::CODE_POS_ZERO) begin
            rep_cnt_reg <= rep_next;
         end else begin
            rep_cnt_reg <= 4'h0;
         end
      end else if (gap_cnt_reg != GAP_W'(esr_pkg::GAP_CYC)) begin
         gap_cnt_reg <= gap_cnt_reg + 1'b1;
      end
   end

   // Zero point: taken on accept, restored from NV at the end of init
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         offset_reg <= 48'h0000_0000_0000;
      end else if (accept_rst && rx_data == esr_pkg::CODE_POS_ZERO) begin
         offset_reg <= position_in;
      end else if (init_done) begin
         offset_reg <= nv_offset_in;
      end
   end
   assign nv_write_data = offset_reg;

   // Fault latches; a new cause wins over a clear in the same cycle
   always_comb begin
      lat_set = 8'h00;
      if (state_reg != esr_pkg::ST_INIT) begin
         lat_set[esr_pkg::ALM_OVERSPEED] = overspeed_in;
         lat_set[esr_pkg::ALM_LOWAMP] = low_amp_in;
      end else begin
         lat_set[esr_pkg::ALM_NVHW] = nv_fault_in;
         lat_set[esr_pkg::ALM_INIT] = nv_fault_in || pos_invalid_in;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lat_reg <= 8'h00;
         init_fault_reg <= 1'b0;
      end else begin
         lat_reg <= lat_reg | lat_set;
         if (accept_rst && rx_data == esr_pkg::CODE_ERR_RST) begin
            lat_reg <= (lat_reg & ~esr_pkg::ALM_CLR_ON_RESET) | lat_set;
            init_fault_reg <= 1'b0;
         end else if (init_done) begin
            lat_reg[esr_pkg::ALM_INIT] <= init_fault_reg || lat_set[esr_pkg::ALM_INIT];
         end else if (lat_set[esr_pkg::ALM_INIT]) begin
            init_fault_reg <= 1'b1;
         end
      end
   end

   // Interrupt events
   always_comb begin
      irq_ev = '0;
      irq_ev[esr_pkg::IRQ_RESP] = tx_ready && tx_valid && (idx_reg == len_reg);
      irq_ev[esr_pkg::IRQ_ERR_RST] = init_done;
      irq_ev[esr_pkg::IRQ_POS_ZERO] = (state_reg == esr_pkg::ST_NV) && nv_write_done;
      irq_ev[esr_pkg::IRQ_ALARM] = |(lat_set & ~lat_reg);
      irq_ev[esr_pkg::IRQ_RX_FAULT] = rx_err;
   end

   // AHB-Lite slave, zero wait states
   assign ap_valid = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= ap_valid && hwrite;
         wr_addr_reg <= haddr[esr_pkg::ADDR_W-1:0];
      end
   end

   // Read data registered at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         case (haddr[esr_pkg::ADDR_W-1:0])
            esr_pkg::REG_CTRL: hrdata <= {30'h0000_0000, ctrl_reg};
            esr_pkg::REG_STATE: hrdata <= {8'h00, 2'h0, state_reg, rep_cnt_reg, sf, alarm_code_byte};
            esr_pkg::REG_IRQ_STAT: hrdata <= {27'h000_0000, irq_stat_reg};
            esr_pkg::REG_IRQ_MASK: hrdata <= {27'h000_0000, irq_mask_reg};
            esr_pkg::REG_POS_LO: hrdata <= pos48[31:0];
            esr_pkg::REG_POS_HI: hrdata <= {16'h0000, pos48[47:32]};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Writable registers; status bits clear on writing one, events win
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= esr_pkg::CTRL_RESET;
         irq_mask_reg <= '0;
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_ev;
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               esr_pkg::REG_CTRL: ctrl_reg <= hwdata[1:0];
               esr_pkg::REG_IRQ_MASK: irq_mask_reg <= hwdata[esr_pkg::NUM_IRQ-1:0];
               esr_pkg::REG_IRQ_STAT:
                  irq_stat_reg <= (irq_stat_reg & ~hwdata[esr_pkg::NUM_IRQ-1:0]) | irq_ev;
               default: ;
            endcase
         end
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : esr_encoder_link

// >>> testbench/esr_encoder_link_asserts.sv
// Purpose: Port checks of the answer line, bus and NV store handshake.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Register contents are judged by the bench, not here.
`timescale 1ns/1ps
module esr_encoder_link_asserts (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, low active
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic hready, // Bus ready
   input wire logic [31:0] hrdata, // Read data
   input wire logic line_out, // Answer line
   input wire logic line_oe_n, // Driver on, low
   input wire logic nv_write_req, // NV store request
   input wire logic nv_write_done // NV store done
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Read taken at an address with no register behind it
   sequence hole_rd_s;
      hsel && htrans[1] && hready && !hwrite && haddr == 32'h100;
   endsequence
   // Start bit driven low with the driver on
   sequence start_s;
      !line_out ##1 (!line_out && !line_oe_n)[*8];
   endsequence
   hole_read_a: assert property (hole_rd_s |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   line_idle_a: assert property (line_oe_n |-> line_out)
      else $error("line not high while released");
   start_bit_a: assert property ($fell(line_oe_n) |-> start_s)
      else $error("answer does not open with a start bit");
   cell_len_a: assert property ($fell(line_out) |-> (!line_out)[*8])
      else $error("low bit cell too short");
   delim_end_a: assert property ($rose(line_oe_n) |-> $past(line_out) && $past(line_out, 8))
      else $error("driver released before delimiter");
   nv_hold_a: assert property (nv_write_req && !nv_write_done |=> nv_write_req)
      else $error("NV request dropped early");
   nv_drop_a: assert property (nv_write_req && nv_write_done |=> !nv_write_req)
      else $error("NV request kept after done");
   nv_quiet_a: assert property (nv_write_req |-> line_oe_n)
      else $error("answer sent during NV store");
endmodule : esr_encoder_link_asserts
bind esr_encoder_link esr_encoder_link_asserts i_esr_encoder_link_asserts (.hclk, .hresetn,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .line_out, .line_oe_n, .nv_write_req,
   .nv_write_done);

// >>> testbench/esr_servo_master.sv
// Purpose: Servo-side model: sends request bytes, collects answer bytes.
// Assumes: Answer bits sampled mid-cell on the falling clock edge.
// Notes: Request line idles high, as the bus bias holds it.
`timescale 1ns/1ps
module esr_servo_master #(
   parameter int BIT_CYC = 16
) (
   input wire logic hclk, // System clock
   output logic line_in, // Request line
   input wire logic line_out, // Answer line
   input wire logic line_oe_n // Encoder driving, low
);
   logic [7:0] rx_q [$]; // Answer bytes in order
   logic [7:0] b;
   int frame_errs = 0; // Bad delimiters
   initial line_in = 1'b1;
   // Start low, data LSB first, delimiter high
   task automatic send(input logic [7:0] code);
      logic [9:0] f;
      f = {1'b1, code, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_in <= f[i];
         repeat (BIT_CYC) @(posedge hclk);
      end
   endtask : send
   // Falling edge sampling keeps clear of the encoder's own updates
   initial forever begin
      @(negedge hclk);
      if (line_oe_n === 1'b0 && line_out === 1'b0) begin
         repeat (BIT_CYC / 2) @(negedge hclk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge hclk);
            b[i] = line_out;
         end
         repeat (BIT_CYC) @(negedge hclk);
         frame_errs += (line_out !== 1'b1);
         rx_q.push_back(b);
      end
   end
endmodule : esr_servo_master

// >>> testbench/tb_esr_encoder_link.sv
// Purpose: Self-checking bench for the encoder link.
// Assumes: Init cut to 50 cycles; the servo model reads the answers.
// Notes: All compares go through chk.
`timescale 1ns/1ps
module tb_esr_encoder_link;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, overspeed_in = 1'b0;
   logic low_amp_in = 1'b0, nv_write_done = 1'b0, hreadyout, hresp, irq, line_in, line_out;
   logic line_oe_n, nv_write_req, nv_fault_in = 1'b0, pos_invalid_in = 1'b0;
   logic [1:0] htrans = 2'h0, warn_in = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [47:0] position_in = 48'h0, nv_write_data, nv_offset_in = 48'h0;
   logic [7:0] ans [9];
   int errors = 0, cmp_count = 0;
   esr_encoder_link #(.INIT_CYCLES(50), .BIT_CYC(16)) i_esr_encoder_link (.hclk, .hresetn, .hsel,
      .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .irq, .line_in, .line_out, .line_oe_n, .position_in, .overspeed_in, .low_amp_in,
      .nv_fault_in, .pos_invalid_in, .warn_in, .nv_offset_in, .nv_write_req,
      .nv_write_data, .nv_write_done);
   esr_servo_master #(.BIT_CYC(16)) i_esr_servo_master (.hclk, .line_in, .line_out, .line_oe_n);
   always #12.5 hclk = ~hclk;
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Single transfer; read data lands in rd
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // Request, wait for n answer bytes (or silence), check echo and check byte
   task automatic ask(input logic [7:0] code, input int n);
      logic [7:0] x;
      i_esr_servo_master.send(code);
      for (int k = 0; k < 3000 && (n == 0 || i_esr_servo_master.rx_q.size() < n); k++)
         @(posedge hclk);
      chk(48'(i_esr_servo_master.rx_q.size()), 48'(n));
      x = 8'h0;
      for (int i = 0; i < n; i++) begin
         ans[i] = i_esr_servo_master.rx_q.pop_front();
         x ^= (i < n - 1) ? ans[i] : 8'h0;
      end
      if (n > 0) chk({ans[0], ans[n - 1]}, {code, x});
      repeat (600) @(posedge hclk);
   endtask : ask
   task automatic t_regs();
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[21:20], 48'h0);
      chk({hresp, hreadyout}, 48'h1);
      repeat (60) @(posedge hclk);
      ahb(1'b0, 32'h4, 32'h0);
      chk({rd[21:20], rd[7:0]}, 48'h100);
      ahb(1'b0, 32'h100, 32'h0);
      chk(rd, 48'h0);
      ahb(1'b1, 32'hC, 32'h2);
      @(posedge hclk);
      chk(irq, 48'h1);
      ahb(1'b1, 32'h8, 32'h2);
      @(posedge hclk);
      chk(irq, 48'h0);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_reads();
      position_in <= 48'h54_3210;
      ask(8'hA2, 7);
      chk(ans[6], 48'hD4);
      position_in <= 48'hF4_3210;
      for (int r = 0; r < 4; r++) begin
         ahb(1'b1, 32'h0, 32'(r));
         ask(8'hA2, 7);
         chk({ans[4], ans[3], ans[2]}, 48'hF4_3210 & (48'hFF_FFFF >> ((r == 3) ? 4 : r)));
         chk({ans[1], ans[5]}, 48'h0);
      end
      position_in <= 48'h8765_43F4_3210;
      ask(8'h2A, 9);
      chk({ans[7], ans[6], ans[5], ans[4], ans[3], ans[2]}, 48'h8765_43F4_3210);
      chk(i_esr_servo_master.frame_errs, 48'h0);
      $display("t_reads done");
   endtask : t_reads
   task automatic t_err();
      warn_in <= 2'h1;
      overspeed_in <= 1'b1;
      low_amp_in <= 1'b1;
      ahb(1'b0, 32'h4, 32'h0);
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[15:0], 48'hC061);
      warn_in <= 2'h0;
      overspeed_in <= 1'b0;
      low_amp_in <= 1'b0;
      for (int i = 0; i < 3; i++) ask(8'hDA, 7);
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[19:0], 48'h3_8021);
      ask(8'hA2, 7);
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[19:16], 48'h0);
      for (int i = 0; i < 9; i++) ask(8'hDA, 7);
      chk({ans[1], ans[5]}, 48'h8021);
      {nv_fault_in, pos_invalid_in} <= 2'b11;
      ask(8'hDA, 0);
      {nv_fault_in, pos_invalid_in} <= 2'b00;
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[21:0], 48'h10_8006);
      $display("t_err done");
   endtask : t_err
   task automatic t_zero();
      position_in <= 48'h12_3456;
      for (int i = 0; i < 9; i++) ask(8'h7A, 7);
      ask(8'h7A, 0);
      chk(nv_write_req, 48'h1);
      chk(nv_write_data, 48'h12_3456);
      ask(8'hA2, 0);
      nv_write_done <= 1'b1;
      @(posedge hclk);
      nv_write_done <= 1'b0;
      ask(8'hA2, 7);
      chk({ans[4], ans[3], ans[2]}, 48'h0);
      $display("t_zero done");
   endtask : t_zero
   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_reads();
      t_err();
      t_zero();
      conclude();
   end
   // Watchdog well past the expected run of about 70000 cycles
   initial begin
      repeat (95000) @(posedge hclk);
      errors++;
      conclude();
   end
endmodule : tb_esr_encoder_link
